/* design/ufsf_defs.vh */
// constants for the usb function status flag block
`ifndef UFSF_DEFS_VH
`define UFSF_DEFS_VH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define UFSF_ADDR_W          16
`define UFSF_DATA_W          8

// ----------------------------------------------------------------
// register addresses on the microcontroller data bus
// ----------------------------------------------------------------
`define UFSF_ADDR_MASK       16'hF007
`define UFSF_ADDR_STATUS     16'hF008
`define UFSF_ADDR_WAKE_EVT   16'hF009

// ----------------------------------------------------------------
// usb_event_status bit positions
// ----------------------------------------------------------------
`define UFSF_BIT_SETUP_OVW   0
`define UFSF_BIT_SETUP       1
`define UFSF_BIT_WAKE_CLK    2
`define UFSF_BIT_RESUME      3
`define UFSF_BIT_SUSPEND     4
`define UFSF_BIT_FUNC_RST    5
`define UFSF_FLAG_CNT        6

// ----------------------------------------------------------------
// wakeup_pin_events bit positions
// ----------------------------------------------------------------
`define UFSF_WBIT_VBUS       0
`define UFSF_WBIT_PIN_A      1
`define UFSF_WBIT_PIN_B      2
`define UFSF_WBIT_PIN_C      3
`define UFSF_WBIT_PIN_D      4
`define UFSF_WAKE_CNT        5

// ----------------------------------------------------------------
// reset values and the set level
// ----------------------------------------------------------------
`define UFSF_RST_BYTE        8'h00
`define UFSF_RST_BIT         1'b0
`define UFSF_SET_BIT         1'b1

`endif

/* design/ufsf_flag.v */
// bank of sticky write-one-to-clear flags with a synchronous wipe
`timescale 1ns/100ps
`default_nettype none
`include "ufsf_defs.vh"

module ufsf_flag #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // hardware set, software clear, reset-like wipe
  input  wire [WIDTH-1:0] set,
  input  wire [WIDTH-1:0] clear,
  input  wire             wipe,
  // flag state
  output reg  [WIDTH-1:0] q
);

  reg [WIDTH-1:0] next_q;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // wipe models a reset and beats everything; a set beats a clear so
  // an event landing in the clearing cycle is never lost
  always @* begin
    if (wipe) begin
      next_q = {WIDTH{`UFSF_RST_BIT}};
    end else begin
      next_q = (q & ~clear) | set;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // flag register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= {WIDTH{`UFSF_RST_BIT}};
    end else begin
      q <= next_q;
    end
  end

endmodule
`default_nettype wire

/* design/ufsf_change.v */
// level change detector producing one-cycle pulses per input bit
`timescale 1ns/100ps
`default_nettype none
`include "ufsf_defs.vh"

module ufsf_change #(
  parameter WIDTH = 5
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // monitored levels and change pulses
  input  wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] change
);

  reg [WIDTH-1:0] prev;
  reg             primed;

  // ----------------------------------------------------------------
  // history
  // ----------------------------------------------------------------
  // primed blocks a false change on the first sample after reset,
  // when prev still holds its reset value rather than the pin level
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev   <= {WIDTH{`UFSF_RST_BIT}};
      primed <= `UFSF_RST_BIT;
    end else begin
      prev   <= level;
      primed <= `UFSF_SET_BIT;
    end
  end

  // change pulse per bit
  assign change = (prev ^ level) & {WIDTH{primed}};

endmodule
`default_nettype wire

/* design/ufsf_top.v */
// usb function event status flags, mask and shared interrupt
//
// Summary of operation
// - interrupt only while matching mask bit set
// - clearing a flag withdraws its interrupt
// - hardware sets flags, write one clears
// - power-up/watchdog reset clear all flags, function reset included
// - bus reset clears flags when control bit set
// - bus reset sets function reset flag
// - function reset flag set on host port reset
// - wakeup flag set by pin change when enabled
// - wakeup interrupt restarts stopped clock if allowed
// - wakeup flag means change since pin bit cleared
// - suspend flag set on global or selective suspend
// - clearing wakeup flag clears shared wakeup interrupt
`timescale 1ns/100ps
`default_nettype none
`include "ufsf_defs.vh"

module ufsf_top #(
  parameter ADDR_W = `UFSF_ADDR_W,
  parameter DATA_W = `UFSF_DATA_W
) (
  // clock and power-up reset
  input  wire              CLK_SYS,
  input  wire              RST_N,
  // watchdog reset, one or more cycles high
  input  wire              WDT_RESET,
  // microcontroller data bus
  input  wire [ADDR_W-1:0] ADDR,
  input  wire              WR_EN,
  input  wire [DATA_W-1:0] WR_DATA,
  input  wire              RD_EN,
  output reg  [DATA_W-1:0] RD_DATA,
  output reg               RD_VALID,
  // bus event detectors
  input  wire              SETUP_RCVD,
  input  wire              SETUP_OVERWRITE,
  input  wire              RESUME_DET,
  input  wire              SUSPEND_DET,
  input  wire              BUS_RESET,
  // control bits held elsewhere in usb_function_control
  input  wire              BUS_RESET_CLEARS_FLAGS,
  input  wire              REMOTE_WAKE_EN,
  input  wire              CORE_CLK_STOPPED,
  // wakeup-capable levels
  input  wire              VBUS,
  input  wire              WAKE_PIN_A,
  input  wire              WAKE_PIN_B,
  input  wire              WAKE_PIN_C,
  input  wire              WAKE_PIN_D,
  // interrupt and clock wake request
  output reg               MCU_IRQ,
  output reg               CLK_RESTART_REQ
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wire                      sel_status;
  wire                      sel_mask;
  wire                      sel_wake;
  wire                      wr_status;
  wire                      wr_mask;
  wire                      wr_wake;
  wire [DATA_W-1:0]         status_clr;
  wire [DATA_W-1:0]         wake_clr;
  wire                      wipe_flags;
  wire                      wipe_func_rst;
  wire [`UFSF_WAKE_CNT-1:0] wake_levels;
  wire [`UFSF_WAKE_CNT-1:0] wake_change;
  wire [`UFSF_WAKE_CNT-1:0] wake_events;
  wire                      wake_any;
  wire                      wake_set;
  wire                      setup_ovw_flag;
  wire                      setup_flag;
  wire                      wakeup_clock_flag;
  wire                      resume_flag;
  wire                      suspend_request_flag;
  wire                      function_reset_flag;
  wire [`UFSF_FLAG_CNT-1:0] flags;
  wire [DATA_W-1:0]         status_byte;
  wire [DATA_W-1:0]         mask_byte;
  wire [DATA_W-1:0]         wake_byte;
  reg  [`UFSF_FLAG_CNT-1:0] usb_event_mask;
  reg  [`UFSF_FLAG_CNT-1:0] next_mask;
  reg  [DATA_W-1:0]         next_rd_data;
  wire                      next_irq;
  wire                      next_clk_restart;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // full compare, so aliases of the registers never exist
  assign sel_status = (ADDR == `UFSF_ADDR_STATUS);
  assign sel_mask   = (ADDR == `UFSF_ADDR_MASK);
  assign sel_wake   = (ADDR == `UFSF_ADDR_WAKE_EVT);

  // write strobes per register
  assign wr_status = WR_EN & sel_status;
  assign wr_mask   = WR_EN & sel_mask;
  assign wr_wake   = WR_EN & sel_wake;

  // write one clears
  // a zero in the written byte leaves the matching flag untouched
  assign status_clr = WR_DATA & {DATA_W{wr_status}};
  assign wake_clr   = WR_DATA & {DATA_W{wr_wake}};

  // ----------------------------------------------------------------
  // reset sources for the flags
  // ----------------------------------------------------------------
  // watchdog clears flags
  // conditional bus reset
  // a usb bus reset only wipes the flags when firmware connected it
  assign wipe_flags = WDT_RESET | (BUS_RESET & BUS_RESET_CLEARS_FLAGS);

  // watchdog only clears
  // the function reset flag survives any bus reset
  assign wipe_func_rst = WDT_RESET;

  // ----------------------------------------------------------------
  // wakeup pin change detection
  // ----------------------------------------------------------------
  // pins arrive synchronous to CLK_SYS, so no synchroniser here
  assign wake_levels[`UFSF_WBIT_VBUS]  = VBUS;
  assign wake_levels[`UFSF_WBIT_PIN_A] = WAKE_PIN_A;
  assign wake_levels[`UFSF_WBIT_PIN_B] = WAKE_PIN_B;
  assign wake_levels[`UFSF_WBIT_PIN_C] = WAKE_PIN_C;
  assign wake_levels[`UFSF_WBIT_PIN_D] = WAKE_PIN_D;

  // one-cycle pulse on each level change
  ufsf_change #(
    .WIDTH (`UFSF_WAKE_CNT)
  ) u_change (
    .clk    (CLK_SYS),
    .rst_n  (RST_N),
    .level  (wake_levels),
    .change (wake_change)
  );

  // per-pin event record
  // bits stay until firmware clears each one individually or a watchdog reset wipes them
  ufsf_flag #(
    .WIDTH (`UFSF_WAKE_CNT)
  ) u_wake_evt (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .set   (wake_change),
    .clear (wake_clr[`UFSF_WAKE_CNT-1:0]),
    .wipe  (WDT_RESET),
    .q     (wake_events)
  );

  // wakeup flag set
  // all pin pulses merge into one; gated by the wakeup mask bit, and
  // once set further changes only show in the per-pin record
  assign wake_any = |wake_change;
  assign wake_set = wake_any & usb_event_mask[`UFSF_BIT_WAKE_CLK];

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // setup overwrite flag
  ufsf_flag #(
    .WIDTH (1)
  ) u_setup_ovw (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .set   (SETUP_OVERWRITE),
    .clear (status_clr[`UFSF_BIT_SETUP_OVW]),
    .wipe  (wipe_flags),
    .q     (setup_ovw_flag)
  );

  ufsf_flag #(
    .WIDTH (1)
  ) u_setup (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .set   (SETUP_RCVD),
    .clear (status_clr[`UFSF_BIT_SETUP]),
    .wipe  (wipe_flags),
    .q     (setup_flag)
  );

  // shared wakeup clear
  // one write clears the single wakeup interrupt for every pin
  ufsf_flag #(
    .WIDTH (1)
  ) u_wake_clk (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .set   (wake_set),
    .clear (status_clr[`UFSF_BIT_WAKE_CLK]),
    .wipe  (wipe_flags),
    .q     (wakeup_clock_flag)
  );

  ufsf_flag #(
    .WIDTH (1)
  ) u_resume (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .set   (RESUME_DET),
    .clear (status_clr[`UFSF_BIT_RESUME]),
    .wipe  (wipe_flags),
    .q     (resume_flag)
  );

  ufsf_flag #(
    .WIDTH (1)
  ) u_suspend (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .set   (SUSPEND_DET),
    .clear (status_clr[`UFSF_BIT_SUSPEND]),
    .wipe  (wipe_flags),
    .q     (suspend_request_flag)
  );

  // function reset flag
  // bus reset is a level; it keeps setting the flag while it lasts,
  // so a firmware clear during the reset does not stick
  ufsf_flag #(
    .WIDTH (1)
  ) u_func_rst (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .set   (BUS_RESET),
    .clear (status_clr[`UFSF_BIT_FUNC_RST]),
    .wipe  (wipe_func_rst),
    .q     (function_reset_flag)
  );

  // gather the flags in register order
  assign flags[`UFSF_BIT_SETUP_OVW] = setup_ovw_flag;
  assign flags[`UFSF_BIT_SETUP]     = setup_flag;
  assign flags[`UFSF_BIT_WAKE_CLK]  = wakeup_clock_flag;
  assign flags[`UFSF_BIT_RESUME]    = resume_flag;
  assign flags[`UFSF_BIT_SUSPEND]   = suspend_request_flag;
  assign flags[`UFSF_BIT_FUNC_RST]  = function_reset_flag;

  // ----------------------------------------------------------------
  // interrupt mask register
  // ----------------------------------------------------------------
  // low six mask bits
  // a bus reset leaves the mask alone; only power-up or watchdog
  always @* begin
    if (WDT_RESET) begin
      next_mask = {`UFSF_FLAG_CNT{`UFSF_RST_BIT}};
    end else if (wr_mask) begin
      next_mask = WR_DATA[`UFSF_FLAG_CNT-1:0];
    end else begin
      next_mask = usb_event_mask;
    end
  end

  // mask storage
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      usb_event_mask <= {`UFSF_FLAG_CNT{`UFSF_RST_BIT}};
    end else begin
      usb_event_mask <= next_mask;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // reserved bits read zero
  assign status_byte = {{(DATA_W-`UFSF_FLAG_CNT){`UFSF_RST_BIT}}, flags};
  assign mask_byte   = {{(DATA_W-`UFSF_FLAG_CNT){`UFSF_RST_BIT}},
                        usb_event_mask};
  assign wake_byte   = {{(DATA_W-`UFSF_WAKE_CNT){`UFSF_RST_BIT}},
                        wake_events};

  // read mux; unmapped addresses answer zero
  always @* begin
    next_rd_data = `UFSF_RST_BYTE;
    if (RD_EN) begin
      if (sel_status) begin
        next_rd_data = status_byte;
      end else if (sel_mask) begin
        next_rd_data = mask_byte;
      end else if (sel_wake) begin
        next_rd_data = wake_byte;
      end else begin
        next_rd_data = `UFSF_RST_BYTE;
      end
    end else begin
      next_rd_data = RD_DATA;
    end
  end

  // ----------------------------------------------------------------
  // interrupt and clock wake
  // ----------------------------------------------------------------
  // masked interrupt
  // clear withdraws interrupt
  // the line is a pure function of flag and mask, so any clear of a
  // flag, the wakeup flag included, drops its share of the interrupt
  assign next_irq = |(flags & usb_event_mask);

  // clock restart request
  // only a live, enabled wakeup interrupt may wake a stopped clock
  assign next_clk_restart = wakeup_clock_flag &
                            usb_event_mask[`UFSF_BIT_WAKE_CLK] &
                            REMOTE_WAKE_EN & CORE_CLK_STOPPED;

  // output registers; outputs come straight from flip-flops
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA         <= `UFSF_RST_BYTE;
      RD_VALID        <= `UFSF_RST_BIT;
      MCU_IRQ         <= `UFSF_RST_BIT;
      CLK_RESTART_REQ <= `UFSF_RST_BIT;
    end else begin
      RD_DATA         <= next_rd_data;
      RD_VALID        <= RD_EN;
      MCU_IRQ         <= next_irq;
      CLK_RESTART_REQ <= next_clk_restart;
    end
  end

endmodule
`default_nettype wire

/* sim/ufsf_top_chk.sv */
// concurrent checks on the ports of the usb function status flag block
`timescale 1ns/100ps
`default_nettype none

module ufsf_chk #(
  parameter ADDR_W = 16,
  parameter DATA_W = 8
) (
  // clock and resets
  input wire logic              CLK_SYS,
  input wire logic              RST_N,
  input wire logic              WDT_RESET,
  // register bus
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic              WR_EN,
  input wire logic              RD_EN,
  input wire logic [DATA_W-1:0] RD_DATA,
  // events and control levels
  input wire logic              SETUP_RCVD,
  input wire logic              SUSPEND_DET,
  input wire logic              BUS_RESET,
  input wire logic              BUS_RESET_CLEARS_FLAGS,
  input wire logic              REMOTE_WAKE_EN,
  input wire logic              CORE_CLK_STOPPED,
  // outputs
  input wire logic              MCU_IRQ,
  input wire logic              CLK_RESTART_REQ
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  // any wipe of flags 0-4 in this cycle
  wire wipe = WDT_RESET | (BUS_RESET & BUS_RESET_CLEARS_FLAGS);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_rd_sta;
    RD_EN && ADDR == 16'hF008;
  endsequence
  // mask is zero after a watchdog and nothing rewrites it
  sequence s_wdt_quiet;
    WDT_RESET ##1 (!WR_EN)[*3];
  endsequence
  sequence s_hold;
    !wipe && !WR_EN;
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_rsv;
    RD_EN |=> RD_DATA[7:6] == 2'b00;
  endproperty
  property p_restart;
    CLK_RESTART_REQ |-> MCU_IRQ && $past(REMOTE_WAKE_EN)
                        && $past(CORE_CLK_STOPPED);
  endproperty
  property p_wdt_irq;
    WDT_RESET |-> ##2 !MCU_IRQ;
  endproperty
  property p_mask_irq;
    s_wdt_quiet |=> !MCU_IRQ;
  endproperty
  property p_func_rst;
    (BUS_RESET && !WDT_RESET) ##1 s_rd_sta |=> RD_DATA[5];
  endproperty
  property p_bus_wipe;
    (BUS_RESET && BUS_RESET_CLEARS_FLAGS && !WDT_RESET) ##1 s_rd_sta
      |=> RD_DATA == 8'h20;
  endproperty
  property p_suspend;
    (SUSPEND_DET && !wipe) ##1 s_hold ##1 s_rd_sta |=> RD_DATA[4];
  endproperty
  property p_setup;
    (SETUP_RCVD && !wipe) ##1 s_hold ##1 s_rd_sta |=> RD_DATA[1];
  endproperty

  a_rsv: assert property (p_rsv)
    else $error("reserved status bits read nonzero");
  a_restart: assert property (p_restart)
    else $error("clock restart without its enables");
  a_wdt_irq: assert property (p_wdt_irq)
    else $error("interrupt survives watchdog");
  a_mask_irq: assert property (p_mask_irq)
    else $error("interrupt with mask clear");
  a_func_rst: assert property (p_func_rst)
    else $error("bus reset left function reset flag low");
  a_bus_wipe: assert property (p_bus_wipe)
    else $error("qualified bus reset did not wipe flags");
  a_suspend: assert property (p_suspend)
    else $error("suspend flag not set");
  a_setup: assert property (p_setup)
    else $error("setup flag not set");
endmodule

bind ufsf_top ufsf_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .WDT_RESET(WDT_RESET), .ADDR(ADDR),
  .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
  .SETUP_RCVD(SETUP_RCVD), .SUSPEND_DET(SUSPEND_DET),
  .BUS_RESET(BUS_RESET), .BUS_RESET_CLEARS_FLAGS(BUS_RESET_CLEARS_FLAGS),
  .REMOTE_WAKE_EN(REMOTE_WAKE_EN), .CORE_CLK_STOPPED(CORE_CLK_STOPPED),
  .MCU_IRQ(MCU_IRQ), .CLK_RESTART_REQ(CLK_RESTART_REQ));
`default_nettype wire

/* sim/tb_ufsf_top.sv */
// self-checking bench for the usb function status flag block
`timescale 1ns/100ps
`default_nettype none

module tb_ufsf_top;
  logic        clk, rst_n, wdt, wr_en, rd_en, brcf, rwake, cstop;
  logic        rd_valid, irq, restart;
  logic [15:0] addr;
  logic [7:0]  wr_data, rd_data, e;
  logic [4:0]  ev;   // bus reset, suspend, resume, setup, overwrite
  logic [4:0]  pins; // pin d, c, b, a, vbus
  int          fail_count, tests_run, i;

  ufsf_top DUT (
    .CLK_SYS(clk), .RST_N(rst_n), .WDT_RESET(wdt), .ADDR(addr),
    .WR_EN(wr_en), .WR_DATA(wr_data), .RD_EN(rd_en), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .SETUP_RCVD(ev[1]), .SETUP_OVERWRITE(ev[0]),
    .RESUME_DET(ev[2]), .SUSPEND_DET(ev[3]), .BUS_RESET(ev[4]),
    .BUS_RESET_CLEARS_FLAGS(brcf), .REMOTE_WAKE_EN(rwake),
    .CORE_CLK_STOPPED(cstop), .VBUS(pins[0]), .WAKE_PIN_A(pins[1]),
    .WAKE_PIN_B(pins[2]), .WAKE_PIN_C(pins[3]), .WAKE_PIN_D(pins[4]),
    .MCU_IRQ(irq), .CLK_RESTART_REQ(restart));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // inputs always move 1 ns after the edge so sampling never races
  task step;
    @(posedge clk);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    addr = a;
    wr_data = v;
    wr_en = 1'b1;
    step;
    wr_en = 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] exp, input string n);
    addr = a;
    rd_en = 1'b1;
    step;
    rd_en = 1'b0;
    chk("rd_valid", {7'h00, rd_valid}, 8'h01);
    chk(n, rd_data, exp);
    // idle edge so a following read never re-raises rd_en at once
    step;
  endtask
  task pulse(input logic [4:0] v);
    ev = v;
    step;
    ev = 5'h00;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // the sequence needs about 140 cycles, so 2500 is ample
  initial begin
    #100000;
    fail_count++;
    wrap_up;
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst_n, wdt, wr_en, rd_en, brcf, rwake, cstop} = 7'h00;
    addr = 16'h0000;
    wr_data = 8'h00;
    ev = 5'h00;
    pins = 5'h00;
    fail_count = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    step;
    rd(16'hF007, 8'h00, "mask_rst");
    rd(16'hF008, 8'h00, "status_rst");
    wr(16'hF00A, 8'hFF);
    rd(16'hF00A, 8'h00, "unmapped");
    wr(16'hF007, 8'hFF);
    rd(16'hF007, 8'h3F, "mask_rsv");
    wr(16'hF007, 8'h00);
    // overwrite, setup, resume and suspend flags: set, interrupt gating, write-0, write-1
    for (i = 0; i < 4; i++) begin
      e = (i < 2) ? (8'h01 << i) : (8'h01 << (i + 1));
      pulse(5'h01 << i);
      step;
      chk("irq_masked", {7'h00, irq}, 8'h00);
      rd(16'hF008, e, "flag_set");
      wr(16'hF007, e);
      step;
      chk("irq_on", {7'h00, irq}, 8'h01);
      wr(16'hF008, ~e);
      rd(16'hF008, e, "w0_keep");
      wr(16'hF008, e);
      step;
      chk("irq_off", {7'h00, irq}, 8'h00);
      rd(16'hF008, 8'h00, "cleared");
    end
    // bus reset with and without the wipe control
    pulse(5'h08);
    step;
    pulse(5'h10);
    rd(16'hF008, 8'h30, "busrst_keep");
    wr(16'hF008, 8'h30);
    brcf = 1'b1;
    pulse(5'h0B);
    step;
    pulse(5'h1B);
    rd(16'hF008, 8'h20, "busrst_wipe");
    brcf = 1'b0;
    // watchdog clears everything, function reset flag too
    wr(16'hF007, 8'h20);
    step;
    chk("irq_rst", {7'h00, irq}, 8'h01);
    wdt = 1'b1;
    step;
    wdt = 1'b0;
    step;
    chk("irq_wdt", {7'h00, irq}, 8'h00);
    rd(16'hF008, 8'h00, "status_wdt");
    rd(16'hF007, 8'h00, "mask_wdt");
    // every wake pin recorded, flag held off while disabled
    for (i = 0; i < 5; i++) begin
      pins[i] = ~pins[i];
      step;
      step;
      rd(16'hF009, 8'h01 << i, "pin_evt");
      rd(16'hF008, 8'h00, "wake_off");
      wr(16'hF009, 8'h01 << i);
    end
    // enabled wake flag, clock restart and shared clear
    wr(16'hF007, 8'h04);
    rwake = 1'b1;
    cstop = 1'b1;
    pins[3] = ~pins[3];
    step;
    step;
    chk("wake_irq", {7'h00, irq}, 8'h01);
    chk("restart", {7'h00, restart}, 8'h01);
    rwake = 1'b0;
    step;
    chk("restart_rwake", {7'h00, restart}, 8'h00);
    rwake = 1'b1;
    rd(16'hF008, 8'h04, "wake_flag");
    pins[1] = ~pins[1];
    step;
    step;
    rd(16'hF009, 8'h0A, "wake_evts");
    wr(16'hF008, 8'h04);
    step;
    chk("wake_clr", {7'h00, irq}, 8'h00);
    chk("restart_clr", {7'h00, restart}, 8'h00);
    rd(16'hF009, 8'h0A, "evt_kept");
    wr(16'hF009, 8'h0A);
    rd(16'hF009, 8'h00, "evt_clr");
    wrap_up;
  end
endmodule
`default_nettype wire
